// ### rtl/focb_pkg.sv
/*
 * shared constants and types of the fast overcurrent blanking block:
 * register offsets, field layout, interval tables and cycle counts.
 * assumes a 100 mhz system clock.
 */
package focb_pkg;

  // ****************************************************************
  // clock and widths
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned PS_PER_NS     = 1000;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned FRAC_W        = 16;
  localparam int unsigned COEF_W        = 42;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [15:0] GAIN_COEF_ADDR  = 16'hfe3c;
  localparam logic [15:0] BLANK_DEB_ADDR  = 16'hfe3d;
  localparam logic [15:0] GAIN_COEF_RESET = 16'h0000;
  localparam logic [7:0]  BLANK_DEB_RESET = 8'h00;

  localparam int unsigned EXP_HI  = 15;
  localparam int unsigned EXP_LO  = 11;
  localparam int unsigned MANT_HI = 9;
  localparam int unsigned MANT_LO = 0;
  localparam int unsigned DEB_HI  = 4;
  localparam int unsigned DEB_LO  = 3;
  localparam int unsigned BLK_HI  = 2;
  localparam int unsigned BLK_LO  = 0;

  // ****************************************************************
  // interval tables, least times rounded up to cycles
  // ****************************************************************
  localparam int unsigned DEB_NS [4]  = '{40, 80, 120, 240};
  localparam int unsigned BLK_NS [8]  = '{40, 80, 120, 160,
                                          200, 400, 600, 800};

  typedef struct packed
  {
    logic signed [4:0] exponent;
    logic        [9:0] mantissa;
  } focb_gain_t;

  typedef struct packed
  {
    logic [1:0] debounce;
    logic [2:0] blanking;
  } focb_cfg_t;

  function automatic logic [CNT_W-1:0] ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction

  function automatic logic [CNT_W-1:0] deb_cycles(input logic [1:0] code);
    return ns_to_cycles(DEB_NS[code]);
  endfunction

  function automatic logic [CNT_W-1:0] blk_cycles(input logic [2:0] code);
    return ns_to_cycles(BLK_NS[code]);
  endfunction

endpackage

// ### rtl/focb_timer.sv
/*
 * interval counter: counts while run is high, clears when low,
 * saturates at the limit and flags done once the limit is reached.
 * assumes a synchronised active-low reset.
 */
`timescale 1ns/1ps
module focb_timer
  import focb_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             run_in,
  input  wire logic [CNT_W-1:0] limit_in,
  output logic                  done_out
);
  import focb_pkg::*;

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  wire              at_limit = (count_q >= limit_in);

  assign count_d  = !run_in  ? '0 :
                    at_limit ? count_q :
                    count_q + {{(CNT_W-1){1'b0}}, 1'b1};
  assign done_out = run_in && at_limit;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      count_q <= '0;
    else
      count_q <= count_d;
  end
endmodule

// ### rtl/focb_top.sv
/*
 * fast overcurrent qualifier: leading edge blanking, debounce and
 * cycle-by-cycle pwm shut-off, plus the input current gain register.
 * assumes pwm request, on-time level, cycle start pulse and comparator
 * result are synchronous to clk_in; registers reached by a simple
 * address/write/read port.
 */
`timescale 1ns/1ps

module focb_top
  import focb_pkg::*;
#(
  parameter int unsigned NUM_PWM = 4
)
(
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic [ADDR_W-1:0]   reg_addr_in,
  input  wire logic                reg_wr_in,
  input  wire logic [DATA_W-1:0]   reg_wdata_in,
  output logic      [DATA_W-1:0]   reg_rdata_out,
  input  wire logic [NUM_PWM-1:0]  pwm_req_in,
  input  wire logic                pwm_on_in,
  input  wire logic                cycle_start_in,
  input  wire logic                overcurrent_cmp_in,
  output logic      [NUM_PWM-1:0]  pwm_out,
  output logic                     trip_out,
  output logic                     blanking_out,
  output focb_pkg::focb_gain_t     gain_out,
  output logic signed [COEF_W-1:0] coef_out
);
  import focb_pkg::*;

  if (NUM_PWM < 1 || NUM_PWM > 32)
  begin : g_chk
    $error("NUM_PWM must be 1 to 32");
  end

  // field builders below assume 16-bit words
  if (DATA_W != 16 || ADDR_W != 16)
  begin : g_chk_bus
    $error("register port must be 16 bits wide");
  end

  // mantissa shifted up to 31 places, plus a sign bit
  localparam int unsigned MANT_W = MANT_HI - MANT_LO + 1;
  if (COEF_W < MANT_W + 32)
  begin : g_chk_coef
    $error("COEF_W too narrow for the coefficient");
  end

  // longest interval must fit the counters
  if ((BLK_NS[7] * PS_PER_NS) / CLK_PERIOD_PS >= (2 ** CNT_W))
  begin : g_chk_cnt
    $error("CNT_W too narrow for the longest interval");
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] reg_at);
    return addr == reg_at;
  endfunction

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  focb_gain_t gain_q;
  focb_cfg_t  cfg_q;

  // reset words cut to the stored fields
  localparam focb_gain_t GAIN_RST = focb_gain_t'(
    {GAIN_COEF_RESET[EXP_HI:EXP_LO], GAIN_COEF_RESET[MANT_HI:MANT_LO]});
  localparam focb_cfg_t  CFG_RST  = focb_cfg_t'(
    {BLANK_DEB_RESET[DEB_HI:DEB_LO], BLANK_DEB_RESET[BLK_HI:BLK_LO]});

  wire              sel_gain = addr_hit(reg_addr_in, GAIN_COEF_ADDR);
  wire              sel_cfg  = addr_hit(reg_addr_in, BLANK_DEB_ADDR);
  wire              wr_gain  = reg_wr_in && sel_gain;
  wire              wr_cfg   = reg_wr_in && sel_cfg;
  wire [DATA_W-1:0] rd_gain = {gain_q.exponent, 1'b0, gain_q.mantissa};
  wire [DATA_W-1:0] rd_cfg  = {8'h00, 3'h0, cfg_q.debounce,
                               cfg_q.blanking};
  wire [DATA_W-1:0] rd_mux  = sel_gain ? rd_gain :
                              sel_cfg  ? rd_cfg :
                              16'h0000;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      gain_q <= GAIN_RST;
    else if (wr_gain)
      gain_q <= {reg_wdata_in[EXP_HI:EXP_LO],
                 reg_wdata_in[MANT_HI:MANT_LO]};
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= CFG_RST;
    else if (wr_cfg)
      cfg_q <= {reg_wdata_in[DEB_HI:DEB_LO], reg_wdata_in[BLK_HI:BLK_LO]};
  end

  // read data follows the address one cycle later
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_out <= 16'h0000;
    else
      reg_rdata_out <= rd_mux;
  end

  // ****************************************************************
  // effective coefficient, fixed point with FRAC_W fraction bits
  // ****************************************************************
  // mantissa shifted by signed exponent
  wire signed [6:0]  shift_s = 7'(FRAC_W) + 7'(gain_q.exponent);
  wire [COEF_W-1:0]  coef_d  = {{(COEF_W-MANT_W){1'b0}}, gain_q.mantissa}
                               << shift_s[5:0];

  // ****************************************************************
  // blanking and debounce
  // ****************************************************************
  logic             blank_done;
  logic             deb_done;
  logic             trip_q;
  logic             trip_d;
  wire [CNT_W-1:0]  blk_lim = blk_cycles(cfg_q.blanking);
  wire [CNT_W-1:0]  deb_lim = deb_cycles(cfg_q.debounce);

  // blanking timer restarts with each on-time
  focb_timer u_blank (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .run_in   (pwm_on_in),
    .limit_in (blk_lim),
    .done_out (blank_done)
  );

  wire blank_active = pwm_on_in && !blank_done;
  wire qualify      = overcurrent_cmp_in && pwm_on_in && !blank_active;

  // continuous above-limit count, cleared on drop
  focb_timer u_deb (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .run_in   (qualify),
    .limit_in (deb_lim),
    .done_out (deb_done)
  );

  // latch trip; new cycle clears, trip wins a tie
  assign trip_d = deb_done ? 1'b1 :
                  cycle_start_in ? 1'b0 : trip_q;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      trip_q <= 1'b0;
    else
      trip_q <= trip_d;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      pwm_out <= '0;
    else
      pwm_out <= trip_d ? '0 : pwm_req_in;
  end

  // blanking seen by the qualifier, one cycle late
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      blanking_out <= 1'b0;
    else
      blanking_out <= blank_active;
  end

  // registered copies of the gain word and coefficient
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      coef_out <= '0;
      gain_out <= GAIN_RST;
    end
    else
    begin
      coef_out <= coef_d;
      gain_out <= gain_q;
    end
  end

  assign trip_out = trip_q;
endmodule

// ### testbench/focb_assertions.sv
/* port checker for focb_top.
   assumes the synchronised copy of reset lags rst_n_in by two edges. */
`timescale 1ns/1ps
module focb_chk
  import focb_pkg::*;
#(
  parameter int unsigned NUM_PWM = 4
)
(
  input wire logic               clk_in,
  input wire logic               rst_n_in,
  input wire logic [ADDR_W-1:0]  reg_addr_in,
  input wire logic [DATA_W-1:0]  reg_rdata_out,
  input wire logic [NUM_PWM-1:0] pwm_req_in,
  input wire logic               pwm_on_in,
  input wire logic               cycle_start_in,
  input wire logic               overcurrent_cmp_in,
  input wire logic [NUM_PWM-1:0] pwm_out,
  input wire logic               trip_out,
  input wire logic               blanking_out
);
  import focb_pkg::*;
  logic [1:0] up_q;
  wire        qual = overcurrent_cmp_in & pwm_on_in;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // skip edges while the internal reset is still held
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  pwm_gate_a: assert property (trip_out |-> pwm_out == '0)
    else $error("pwm active while tripped");
  pwm_pass_a: assert property (up_q == 2'h3 && !trip_out
    |-> pwm_out == $past(pwm_req_in)) else $error("pwm not passed");
  trip_hold_a: assert property (trip_out && !cycle_start_in
    |=> trip_out) else $error("trip dropped in cycle");
  trip_clear_a: assert property (trip_out && cycle_start_in
    && !pwm_on_in |=> !trip_out) else $error("trip kept");
  trip_qual_a: assert property ($rose(trip_out) |-> $past(qual, 2)
    && $past(qual, 3) && $past(qual, 4) && $past(qual, 5))
    else $error("trip without debounce");
  blank_start_a: assert property ($rose(pwm_on_in)
    |-> ##2 blanking_out[*2]) else $error("no blanking");
  blank_quiet_a: assert property ($rose(pwm_on_in) ##1 !trip_out
    |-> !trip_out[*8]) else $error("trip in blanking");
  cfg_resv_a: assert property (reg_addr_in == BLANK_DEB_ADDR
    |=> reg_rdata_out[15:5] == '0) else $error("config reserved");
  gain_resv_a: assert property (reg_addr_in == GAIN_COEF_ADDR
    |=> !reg_rdata_out[10]) else $error("gain reserved");
  cover property ($rose(trip_out));
  cover property ($fell(trip_out));
  cover property ($rose(blanking_out));
endmodule
bind focb_top focb_chk #(.NUM_PWM(NUM_PWM)) chk_u (.clk_in, .rst_n_in,
  .reg_addr_in, .reg_rdata_out, .pwm_req_in, .pwm_on_in, .cycle_start_in,
  .overcurrent_cmp_in, .pwm_out, .trip_out, .blanking_out);

// ### testbench/focb_pwm_model.sv
/* pwm generator and comparator model: one switching cycle per go pulse.
   pat_in bit j is the comparator level in on-time cycle j. */
`timescale 1ns/1ps
module focb_pwm_model
#(
  parameter int unsigned NUM_PWM = 4
)
(
  input  wire logic               clk_in,
  input  wire logic               go_in,
  input  wire logic [127:0]       pat_in,
  output logic      [NUM_PWM-1:0] req_out,
  output logic                    on_out,
  output logic                    start_out,
  output logic                    cmp_out
);
  logic [7:0] ph_q = 8'h00;
  always_ff @(posedge clk_in)
    if (go_in)
      ph_q <= 8'h01;
    else if (ph_q != 8'h00)
      ph_q <= (ph_q == 8'h82) ? 8'h00 : ph_q + 8'h01;
  assign start_out = ph_q == 8'h01;
  assign on_out    = ph_q >= 8'h03 && ph_q <= 8'h7a;
  assign req_out   = on_out ? '1 : '0;
  // comparator chatters while off, which must be ignored
  assign cmp_out   = on_out ? pat_in[ph_q - 8'h03] : ph_q[0];
endmodule

// ### testbench/focb_tb_top.sv
/* self-checking bench for focb_top.
   assumes focb_pwm_model drives the pwm side. */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  errors++; $display("mismatch t=%0t %h %h", $time, a, b); end end
module focb_tb_top;
  import focb_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, wr_q = 1'b0, go = 1'b0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  logic [127:0] pat = '0;
  logic [3:0] req, pwm;
  logic on, st, cmp, trip, blk;
  focb_gain_t gain;
  logic signed [COEF_W-1:0] coef;
  int errors = 0, samples_checked = 0, cyc = 0, nd, nb;
  always #5 clk_in = ~clk_in;
  focb_top #(.NUM_PWM(4)) dut_u (.clk_in, .rst_n_in, .reg_addr_in(addr),
    .reg_wr_in(wr_q), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .pwm_req_in(req), .pwm_on_in(on), .cycle_start_in(st),
    .overcurrent_cmp_in(cmp), .pwm_out(pwm), .trip_out(trip),
    .blanking_out(blk), .gain_out(gain), .coef_out(coef));
  focb_pwm_model #(.NUM_PWM(4)) pwm_u (.clk_in, .go_in(go), .pat_in(pat),
    .req_out(req), .on_out(on), .start_out(st), .cmp_out(cmp));
  task automatic summarize;
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_q <= 1'b1;
    @(posedge clk_in);
    wr_q <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_in);
    addr <= a;
    repeat (2) @(posedge clk_in);
    #1 `CHK(rdata, e)
  endtask
  // comparator high n cycles from on-time cycle s, again after a gap
  task automatic run(input int s, input int n, input int g, input logic t);
    pat = '0;
    for (int i = 0; i < n; i++)
    begin
      pat[s + i] = 1'b1;
      if (g > 0 && s + n + g + i < 120)
        pat[s + n + g + i] = 1'b1;
    end
    @(posedge clk_in);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (8) @(posedge clk_in);
    #1 `CHK(pwm, 4'hf)
    `CHK(blk, (nb > 5))
    repeat (110) @(posedge clk_in);
    #1 `CHK(trip, t)
    `CHK(blk, 1'b0)
    `CHK(pwm, t ? 4'h0 : 4'hf)
    repeat (14) @(posedge clk_in);
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 25000)
    begin
      errors++;
      summarize;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(GAIN_COEF_ADDR, GAIN_COEF_RESET);
    rd(BLANK_DEB_ADDR, {8'h00, BLANK_DEB_RESET});
    wr(GAIN_COEF_ADDR, 16'hffff);
    rd(GAIN_COEF_ADDR, 16'hfbff);
    wr(16'hfe3e, 16'hffff);
    rd(16'hfe3e, 16'h0000);
    wr(GAIN_COEF_ADDR, 16'hf00c);
    rd(GAIN_COEF_ADDR, 16'hf00c);
    `CHK(coef, 42'h00000030000)
    wr(GAIN_COEF_ADDR, 16'h1805);
    rd(GAIN_COEF_ADDR, 16'h1805);
    `CHK(gain, 15'h0c05)
    `CHK(coef, 42'h00000280000)
    for (int d = 0; d < 4; d++)
      for (int b = 0; b < 8; b++)
      begin
        nd = DEB_NS[d] / 10;
        nb = BLK_NS[b] / 10;
        wr(BLANK_DEB_ADDR, {11'h000, d[1:0], b[2:0]});
        rd(BLANK_DEB_ADDR, {11'h000, d[1:0], b[2:0]});
        run(nb, nd + 1, 0, 1'b1);
        run(nb, nd, 0, 1'b0);
        run(0, nb + nd, 0, 1'b0);
        run(nb, nd, 1, 1'b0);
      end
    summarize;
  end
endmodule
